// >>> host_ring_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Host descriptor ring stand-in
// ********************************
module host_ring_model (
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   wb_valid_i,
	input  wire rx_wb_pkg::rx_wb_desc_t desc_i,
	output rx_wb_pkg::rx_wb_desc_t      last_o,
	output logic [15:0]                 count_o,
	output logic [15:0]                 frag_sum_o
);
	// Ring buffers handed out word aligned; buffer one keeps bit zero clear
	localparam logic [63:0] BUF_ADDR [4] = '{64'h0000_0000_0004_0000, 64'h0000_0000_0004_1000,
		64'h0000_0000_0004_2000, 64'h0000_0000_0004_3000};
	// Driver folds UDP fragment sums with end-around carry
	logic [16:0] fold;
	assign fold = {1'b0, frag_sum_o} + {1'b0, desc_i.q0[63:48]};
	// Driver polls done flag; slot is only consumed once it is set
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			count_o    <= 16'h0000;
			last_o     <= '0;
			frag_sum_o <= 16'h0000;
		end else if (wb_valid_i && desc_i.q1[0]) begin
			count_o <= count_o + 16'h0001;
			last_o  <= desc_i;
			if (desc_i.q1[rx_wb_pkg::ST_IP_IDENT_VALID] && desc_i.q1[rx_wb_pkg::ST_UDP_SUM_FLAG]) begin
				frag_sum_o <= fold[15:0] + {15'h0000, fold[16]};
			end
		end
	end
endmodule : host_ring_model
`default_nettype wire

// >>> rx_buffer_allocator.sv
`timescale 1ns/10ps
`default_nettype none
module rx_buffer_allocator #(
	parameter int LEN_W = 16
) (
	input  wire logic [LEN_W-1:0]      total_len_i,
	input  wire logic [9:0]            header_len_i,
	input  wire logic [3:0][LEN_W-1:0] sizes_i,
	input  wire logic                  split_mode_i,
	input  wire logic                  split_capable_i,
	input  wire logic                  continuation_i,
	output logic      [3:0][LEN_W-1:0] lens_o,
	output logic                       headers_split_o,
	output logic      [LEN_W-1:0]      leftover_o
);
	// ****************************************
	// Elaboration check
	// ****************************************
	if (LEN_W < 10) begin : g_bad_width
		$error("LEN_W must hold a header length");
	end
	logic [LEN_W-1:0] hdr_wide;
	logic             hdr_fits;
	logic [LEN_W-1:0] cap [4];
	logic [LEN_W-1:0] rem [5];
	// Header must fit buffer zero, else linear store
	assign hdr_wide = LEN_W'(header_len_i);
	assign hdr_fits = (header_len_i != 10'h000) && (hdr_wide <= sizes_i[0]);
	assign headers_split_o = split_mode_i & split_capable_i & ~continuation_i & hdr_fits;
	// Buffer zero idle on continuation, header only on split
	assign cap[0] = continuation_i ? '0 : (headers_split_o ? hdr_wide : sizes_i[0]);
	assign rem[0] = total_len_i;
	// ****************************************
	// Sequential fill, a zero size takes nothing
	// ****************************************
	for (genvar i = 0; i < 4; i++) begin : g_fill
		if (i > 0) begin : g_cap
			assign cap[i] = sizes_i[i];
		end
		assign lens_o[i] = (rem[i] < cap[i]) ? rem[i] : cap[i];
		assign rem[i+1]  = rem[i] - lens_o[i];
	end
	assign leftover_o = rem[4];
endmodule : rx_buffer_allocator
`default_nettype wire

// >>> rx_descriptor_writeback.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - 12-bit error field at qword one bit 20
// - Error flags at bits 11,10,9,8,6,5,4
// - Error bits 7 and 3:0 stay zero
// - VLAN tag at qword one bit 48
// - Select clear: checksum and ident replace hash
// - Non-IPv4: whole checksum, all four flags clear
// - Fragment no L4: payload sum, ident, UDP flag
// - Split format needs enable and type 01
// - Four addresses, sizes from split register
// - Header never crosses buffers, else no split
// - Zero-sized buffers are never written
// - Continuation descriptors skip buffer zero
// - Split lengths at 1.32, 2.16, 2.32, 2.48
// - Length per buffer, zero when unused
// - Lengths include stored CRC bytes
// - Header status bit 15 marks a split
// - Header length in bits 9:0, buffer zero
module rx_descriptor_writeback #(
	parameter int LEN_W = 16
) (
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	input  wire logic [7:0]             reg_addr_i,
	input  wire logic [31:0]            reg_wdata_i,
	input  wire logic                   reg_write_i,
	input  wire logic                   reg_read_i,
	output logic      [31:0]            reg_rdata_o,
	input  wire logic                   pkt_valid_i,
	input  wire rx_wb_pkg::rx_pkt_info_t pkt_info_i,
	output rx_wb_pkg::rx_wb_desc_t      wb_desc_o,
	output logic                        wb_valid_o,
	output logic      [LEN_W-1:0]       spill_len_o
);
	// ****************************************
	// Elaboration check
	// ****************************************
	if (LEN_W != 16) begin : g_bad_len
		$error("Descriptor length fields are 16 bits wide");
	end
	// Field layout must tile the second quadword without overlap
	if (rx_wb_pkg::ERR_POS < 20) begin : g_bad_err_pos
		$error("Error field overlaps the status field");
	end
	if (rx_wb_pkg::ERR_POS + 12 > rx_wb_pkg::LEN_POS) begin : g_bad_len_pos
		$error("Error field runs into the length field");
	end
	if (rx_wb_pkg::LEN_POS + LEN_W > rx_wb_pkg::VLAN_POS) begin : g_bad_vlan_pos
		$error("Length field runs into the tag field");
	end
	if (rx_wb_pkg::VLAN_POS + 16 > 64) begin : g_bad_tag_end
		$error("Tag field overruns the quadword");
	end
	// Largest buffer size must still fit a length field
	if (8 + rx_wb_pkg::BUF_UNIT_SHIFT > LEN_W) begin : g_bad_unit
		$error("Buffer size unit too large for the length width");
	end

	// ****************************************
	// Control registers
	// ****************************************
	logic [31:0] sum_ctrl;
	logic [31:0] filter_ctrl;
	logic [31:0] rx_ctrl;
	logic [31:0] split_ctrl;
	logic [15:0] done_count;
	logic        last_split;
	logic [31:0] next_rdata;

	// Write decode
	logic wr_sum;
	logic wr_filter;
	logic wr_rx;
	logic wr_split;
	assign wr_sum    = reg_write_i && (reg_addr_i == rx_wb_pkg::REG_SUM_CTRL);
	assign wr_filter = reg_write_i && (reg_addr_i == rx_wb_pkg::REG_FILTER_CTRL);
	assign wr_rx     = reg_write_i && (reg_addr_i == rx_wb_pkg::REG_RX_CTRL);
	assign wr_split  = reg_write_i && (reg_addr_i == rx_wb_pkg::REG_SPLIT_CTRL);

	// Control register storage
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sum_ctrl    <= rx_wb_pkg::SUM_CTRL_RST;
			filter_ctrl <= rx_wb_pkg::FILTER_CTRL_RST;
			rx_ctrl     <= rx_wb_pkg::RX_CTRL_RST;
			split_ctrl  <= rx_wb_pkg::SPLIT_CTRL_RST;
		end else begin
			if (wr_sum) begin
				sum_ctrl <= reg_wdata_i;
			end
			if (wr_filter) begin
				filter_ctrl <= reg_wdata_i;
			end
			if (wr_rx) begin
				rx_ctrl <= reg_wdata_i;
			end
			if (wr_split) begin
				split_ctrl <= reg_wdata_i;
			end
		end
	end

	// ****************************************
	// Register read-back
	// ****************************************
	logic        sel_sum;
	logic        sel_filter;
	logic        sel_rx;
	logic        sel_split;
	logic        sel_status;
	logic [31:0] status_word;
	assign sel_sum     = (reg_addr_i == rx_wb_pkg::REG_SUM_CTRL);
	assign sel_filter  = (reg_addr_i == rx_wb_pkg::REG_FILTER_CTRL);
	assign sel_rx      = (reg_addr_i == rx_wb_pkg::REG_RX_CTRL);
	assign sel_split   = (reg_addr_i == rx_wb_pkg::REG_SPLIT_CTRL);
	assign sel_status  = (reg_addr_i == rx_wb_pkg::REG_STATUS);
	assign status_word = {15'h0000, last_split, done_count};
	// Offsets are distinct, so at most one term is live; unmapped reads zero
	assign next_rdata = ({32{sel_sum}} & sum_ctrl)
		| ({32{sel_filter}} & filter_ctrl)
		| ({32{sel_rx}} & rx_ctrl)
		| ({32{sel_split}} & split_ctrl)
		| ({32{sel_status}} & status_word);

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			reg_rdata_o <= reg_read_i ? next_rdata : 32'h0000_0000;
		end
	end

	// ****************************************
	// Control fields
	// ****************************************
	logic       hash_vs_sum_select;
	logic       ip_payload_sum_enable;
	logic       l4_offload_enable;
	logic [7:0] sum_start_offset;
	logic       extended_status_enable;
	logic [1:0] descriptor_type;
	logic       split_mode;
	assign hash_vs_sum_select     = sum_ctrl[rx_wb_pkg::SUM_HASH_POS];
	assign ip_payload_sum_enable  = sum_ctrl[rx_wb_pkg::SUM_PAYLOAD_POS];
	assign l4_offload_enable      = sum_ctrl[rx_wb_pkg::SUM_L4_POS];
	// Start offset is held only; a nonzero value is a software fault
	assign sum_start_offset       = sum_ctrl[rx_wb_pkg::SUM_START_POS +: 8];
	assign extended_status_enable = filter_ctrl[rx_wb_pkg::FILT_EXT_POS];
	assign descriptor_type        = rx_ctrl[rx_wb_pkg::RXC_DTYPE_POS +: 2];
	// Split format needs both enables together
	assign split_mode = extended_status_enable && (descriptor_type == rx_wb_pkg::DTYPE_SPLIT);

	// Buffer sizes in bytes from the split register
	logic [3:0][LEN_W-1:0] split_buffer_sizes;
	for (genvar b = 0; b < 4; b++) begin : g_size
		assign split_buffer_sizes[b] = LEN_W'({split_ctrl[8*b +: 8], {rx_wb_pkg::BUF_UNIT_SHIFT{1'b0}}});
	end

	// ****************************************
	// Buffer placement
	// ****************************************
	logic [3:0][LEN_W-1:0] buf_lens;
	logic                  headers_split_flag;
	logic [LEN_W-1:0]      leftover;
	rx_buffer_allocator #(
		.LEN_W(LEN_W)
	) u_alloc (
		.total_len_i    (pkt_info_i.length),
		.header_len_i   (pkt_info_i.header_len),
		.sizes_i        (split_buffer_sizes),
		.split_mode_i   (split_mode),
		.split_capable_i(pkt_info_i.split_capable),
		.continuation_i (pkt_info_i.continuation),
		.lens_o         (buf_lens),
		.headers_split_o(headers_split_flag),
		.leftover_o     (leftover)
	);

	// ****************************************
	// Extended error field
	// ****************************************
	logic [11:0] err_field;
	assign err_field = {
		pkt_info_i.errors.rx_data_err,
		pkt_info_i.errors.ipv4_hdr_sum_err,
		pkt_info_i.errors.l4_sum_err,
		pkt_info_i.errors.carrier_ext_err,
		1'b0,
		pkt_info_i.errors.order_fault_flag,
		pkt_info_i.errors.symbol_err_flag,
		pkt_info_i.errors.crc_align_err,
		4'h0
	};

	// ****************************************
	// Checksum and fragment reporting
	// ****************************************
	logic        frag_mode;
	logic        frag_no_l4;
	logic        frag_udp;
	logic        frag_tcp;
	logic        whole_ipv4;
	logic        frag_udp_valid;
	logic        ip_ident_valid;
	logic        udp_sum_flag;
	logic        tcp_sum_flag;
	logic [15:0] pkt_sum;
	// Fragment handling only with payload sums enabled
	assign frag_mode  = pkt_info_i.is_ipv4 && pkt_info_i.is_fragment && ip_payload_sum_enable;
	assign frag_no_l4 = frag_mode && !pkt_info_i.has_udp && !pkt_info_i.has_tcp;
	assign frag_udp   = frag_mode && pkt_info_i.has_udp;
	assign frag_tcp   = frag_mode && pkt_info_i.has_tcp && !pkt_info_i.has_udp;
	assign whole_ipv4 = pkt_info_i.is_ipv4 && !pkt_info_i.is_fragment;

	// Flag table; non-IPv4 leaves all four clear
	assign ip_ident_valid = frag_no_l4 || frag_udp || frag_tcp;
	assign frag_udp_valid = frag_udp && pkt_info_i.udp_sum_valid;
	assign udp_sum_flag   = frag_no_l4 || frag_udp
		|| (whole_ipv4 && l4_offload_enable && pkt_info_i.has_udp);
	assign tcp_sum_flag   = whole_ipv4 && l4_offload_enable
		&& (pkt_info_i.has_tcp || pkt_info_i.has_udp);

	// Payload sum for UDP and no-L4 fragments, whole sum otherwise (TCP fragments too)
	assign pkt_sum = (frag_no_l4 || frag_udp) ? pkt_info_i.payload_sum
		: pkt_info_i.whole_sum;

	// ****************************************
	// Extended status field
	// ****************************************
	logic [19:0] status_field;
	always_comb begin
		status_field = 20'h00000;
		status_field[rx_wb_pkg::ST_DONE]  = 1'b1;
		status_field[rx_wb_pkg::ST_EOP]   = pkt_info_i.eop;
		status_field[rx_wb_pkg::ST_VLAN]  = pkt_info_i.vlan_present;
		status_field[rx_wb_pkg::ST_UDP_SUM_FLAG] = udp_sum_flag;
		status_field[rx_wb_pkg::ST_TCP_SUM_FLAG] = tcp_sum_flag;
		status_field[rx_wb_pkg::ST_IPCS]  = pkt_info_i.is_ipv4;
		status_field[rx_wb_pkg::ST_IP_IDENT_VALID] = ip_ident_valid;
		status_field[rx_wb_pkg::ST_FRAG_UDP_VALID]  = frag_udp_valid;
		status_field[rx_wb_pkg::ST_KIND +: 4] = pkt_info_i.pkt_kind;
	end

	// ****************************************
	// Quadword assembly
	// ****************************************
	logic [63:0] q0_word;
	logic [63:0] q1_word;
	logic [63:0] q2_word;
	logic [15:0] len_field;
	logic [15:0] hdr_status;

	// Shared space: hash, or checksum and identification
	always_comb begin
		q0_word = 64'h0000_0000_0000_0000;
		q0_word[31:0] = pkt_info_i.queue_info;
		if (hash_vs_sum_select) begin
			q0_word[63:32] = pkt_info_i.rss_hash;
		end else begin
			q0_word[63:48] = pkt_sum;
			q0_word[47:32] = ip_ident_valid ? pkt_info_i.ip_ident : 16'h0000;
		end
	end

	// Split format reports buffer zero's share, else the packet
	assign len_field = split_mode ? buf_lens[0] : pkt_info_i.length;

	// Second quadword: status, errors, length, tag
	always_comb begin
		q1_word = 64'h0000_0000_0000_0000;
		q1_word[19:0] = status_field;
		q1_word[rx_wb_pkg::ERR_POS +: 12] = err_field;
		q1_word[rx_wb_pkg::LEN_POS +: 16] = len_field;
		q1_word[rx_wb_pkg::VLAN_POS +: 16] = pkt_info_i.vlan_tag;
	end

	// Header status: split flag and analysed length
	always_comb begin
		hdr_status = 16'h0000;
		hdr_status[rx_wb_pkg::HSPLIT_BIT] = headers_split_flag;
		hdr_status[9:0] = headers_split_flag ? pkt_info_i.header_len : 10'h000;
	end

	// Third quadword carries the other three lengths
	assign q2_word = {buf_lens[3], buf_lens[2], buf_lens[1], hdr_status};

	// ****************************************
	// Write-back register
	// ****************************************
	rx_wb_pkg::rx_wb_desc_t next_desc;
	always_comb begin
		next_desc = '0;
		next_desc.split_format = split_mode;
		next_desc.q0 = q0_word;
		next_desc.q1 = q1_word;
		// Extended format has only two quadwords; the rest stays zero
		if (split_mode) begin
			next_desc.q2 = q2_word;
		end
		next_desc.q3 = 64'h0000_0000_0000_0000;
	end

	// Whole descriptor lands in one cycle so done never leads the data
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wb_desc_o   <= '0;
			wb_valid_o  <= 1'b0;
			spill_len_o <= '0;
		end else begin
			wb_valid_o <= pkt_valid_i;
			if (pkt_valid_i) begin
				wb_desc_o   <= next_desc;
				spill_len_o <= split_mode ? leftover : '0;
			end
		end
	end

	// ****************************************
	// Status counters
	// ****************************************
	// Count wraps; software reads it as a progress hint
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			done_count <= 16'h0000;
			last_split <= 1'b0;
		end else if (pkt_valid_i) begin
			done_count <= done_count + 16'h0001;
			last_split <= headers_split_flag;
		end
	end
endmodule : rx_descriptor_writeback
`default_nettype wire

// >>> rx_descriptor_writeback_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rx_descriptor_writeback_tb;
	logic                    clock_i;
	logic                    rst_n_i;
	logic [7:0]              reg_addr_i;
	logic [31:0]             reg_wdata_i;
	logic                    reg_write_i;
	logic                    reg_read_i;
	logic [31:0]             reg_rdata_o;
	logic [31:0]             rdata;
	logic                    pkt_valid_i;
	logic                    wb_valid_o;
	logic [15:0]             spill_len_o;
	logic [15:0]             count;
	logic [15:0]             sent;
	logic [15:0]             frag_sum;
	rx_wb_pkg::rx_pkt_info_t pkt_info_i;
	rx_wb_pkg::rx_pkt_info_t info;
	rx_wb_pkg::rx_wb_desc_t  wb_desc_o;
	rx_wb_pkg::rx_wb_desc_t  d;
	int                      err_count;
	int                      checked;
	// Expected tables
	int          epos[7] = '{4, 5, 6, 8, 9, 10, 11};
	logic [1:0]  vv[6]   = '{2'b00, 2'b01, 2'b11, 2'b01, 2'b01, 2'b00};
	logic [1:0]  tu[6]   = '{2'b00, 2'b01, 2'b01, 2'b01, 2'b00, 2'b11};
	logic [31:0] ck[6]   = '{32'h1111_0000, 32'h5555_3333, 32'h5555_3333, 32'h5555_3333, 32'h1111_3333, 32'h1111_0000};
	logic [15:0] tot[3]  = '{16'h0258, 16'h0258, 16'h00c8};
	logic [15:0] hdr[3]  = '{16'h0040, 16'h012c, 16'h0040};
	logic [15:0] l0[3]   = '{16'h0040, 16'h0100, 16'h0000};
	logic [15:0] hs[3]   = '{16'h8040, 16'h0000, 16'h0000};
	logic [15:0] sp[3]   = '{16'h0198, 16'h00d8, 16'h0048};
	rx_descriptor_writeback rx_descriptor_writeback_i (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o), .pkt_valid_i(pkt_valid_i), .pkt_info_i(pkt_info_i),
		.wb_desc_o(wb_desc_o), .wb_valid_o(wb_valid_o), .spill_len_o(spill_len_o)
	);
	host_ring_model host_ring_model_i (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_valid_i(wb_valid_o),
		.desc_i(wb_desc_o), .last_o(d), .count_o(count), .frag_sum_o(frag_sum)
	);
	// ********************************
	// Tasks
	// ********************************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		reg_write_i <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
	endtask : wr
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clock_i);
		reg_read_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_read_i <= 1'b0;
		#1;
		rdata = reg_rdata_o;
	endtask : rd
	// Extra cycle so the ring model has taken the slot
	task automatic send();
		@(posedge clock_i);
		pkt_valid_i <= 1'b1;
		pkt_info_i  <= info;
		@(posedge clock_i);
		pkt_valid_i <= 1'b0;
		#1;
		check(wb_valid_o, 1'b1);
		@(posedge clock_i);
		#1;
		sent++;
	endtask : send
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// ********************************
	// Clock, watchdog, tests
	// ********************************
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// Tests need about a hundred cycles
	initial begin
		repeat (4000) @(posedge clock_i);
		err_count++;
		tally_and_finish();
	end
	initial begin
		rst_n_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		reg_write_i = 1'b0;
		reg_read_i = 1'b0;
		pkt_valid_i = 1'b0;
		pkt_info_i = '0;
		info = '0;
		err_count = 0;
		checked = 0;
		sent = 16'h0;
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		// Reset values; unmapped write must not land
		wr(8'h20, 32'h0000_00ff);
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4));
			check(rdata, 64'h0);
		end
		wr(rx_wb_pkg::REG_SUM_CTRL, 32'h0000_2000);
		info.length = 16'h05dc;
		info.vlan_tag = 16'h0123;
		info.rss_hash = 32'h1234_5678;
		info.queue_info = 32'h0000_0005;
		info.whole_sum = 16'h1111;
		info.payload_sum = 16'h5555;
		info.ip_ident = 16'h3333;
		// Walk each error flag through its slot
		for (int i = 0; i < 7; i++) begin
			info.errors = 7'(1 << i);
			send();
			check(d.q1[31:20], 12'h001 << epos[i]);
		end
		check(d.q0, {32'h1234_5678, 32'h0000_0005});
		check(d.q1[63:32], {16'h0123, 16'h05dc});
		check(d.q2 | d.q3, 64'h0);
		info.errors = '0;
		// Fragments 1-3 fold to all ones; 4 is a TCP fragment, 5 whole UDP
		wr(rx_wb_pkg::REG_SUM_CTRL, 32'h0000_0300);
		for (int k = 0; k < 6; k++) begin
			info.is_ipv4 = (k != 0);
			info.is_fragment = (k != 0) && (k != 5);
			info.has_udp = (k == 2) || (k == 3) || (k == 5);
			info.has_tcp = (k == 4);
			info.udp_sum_valid = (k == 2);
			send();
			check(d.q0[63:32], ck[k]);
			check(d.q1[10:9], vv[k]);
			check(d.q1[5:4], tu[k]);
		end
		check(frag_sum, 16'hffff);
		// Split: 256 and 128 byte buffers, last two zero-sized
		wr(rx_wb_pkg::REG_FILTER_CTRL, 32'h0000_8000);
		wr(rx_wb_pkg::REG_RX_CTRL, 32'h0000_0400);
		wr(rx_wb_pkg::REG_SPLIT_CTRL, 32'h0000_0102);
		info.split_capable = 1'b1;
		for (int s = 0; s < 3; s++) begin
			info.length = tot[s];
			info.header_len = hdr[s][9:0];
			info.continuation = (s == 2);
			send();
			check(d.q1[47:32], l0[s]);
			check({d.split_format, d.q2[47:0]}, {1'b1, 16'h0, 16'h0080, hs[s]});
			check(spill_len_o, sp[s]);
			check(d.q3, 64'h0);
			rd(rx_wb_pkg::REG_STATUS);
			check(rdata[16], hs[s][15]);
		end
		// Wrong descriptor type falls back to extended
		wr(rx_wb_pkg::REG_RX_CTRL, 32'h0000_0800);
		send();
		check(d.split_format, 1'b0);
		check(d.q2, 64'h0);
		// Right type but extended status off is no split either
		wr(rx_wb_pkg::REG_RX_CTRL, 32'h0000_0400);
		wr(rx_wb_pkg::REG_FILTER_CTRL, 32'h0000_0000);
		send();
		check(d.split_format, 1'b0);
		check(d.q1[47:32], info.length);
		// Status is read-only
		wr(rx_wb_pkg::REG_STATUS, 32'hffff_ffff);
		rd(rx_wb_pkg::REG_STATUS);
		check(rdata, {16'h0000, sent});
		check(count, sent);
		tally_and_finish();
	end
endmodule : rx_descriptor_writeback_tb
bind rx_descriptor_writeback rx_wb_monitor #(.LEN_W(LEN_W)) rx_wb_monitor_i (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
	.reg_rdata_o(reg_rdata_o), .pkt_valid_i(pkt_valid_i), .pkt_info_i(pkt_info_i),
	.wb_desc_o(wb_desc_o), .wb_valid_o(wb_valid_o), .spill_len_o(spill_len_o)
);
`default_nettype wire

// >>> rx_wb_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Descriptor write-back checker
// ********************************
module rx_wb_monitor #(
	parameter int LEN_W = 16
) (
	input wire logic                    clock_i,
	input wire logic                    rst_n_i,
	input wire logic [7:0]              reg_addr_i,
	input wire logic [31:0]             reg_wdata_i,
	input wire logic                    reg_write_i,
	input wire logic                    reg_read_i,
	input wire logic [31:0]             reg_rdata_o,
	input wire logic                    pkt_valid_i,
	input wire rx_wb_pkg::rx_pkt_info_t pkt_info_i,
	input wire rx_wb_pkg::rx_wb_desc_t  wb_desc_o,
	input wire logic                    wb_valid_o,
	input wire logic [LEN_W-1:0]        spill_len_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Packet taken, then its descriptor one cycle later
	sequence took_s;
		pkt_valid_i ##1 wb_valid_o;
	endsequence
	sequence ext_s;
		took_s ##0 !wb_desc_o.split_format;
	endsequence
	// Strobe timing
	wb_follows_a: assert property (pkt_valid_i |=> wb_valid_o)
		else $error("no descriptor after packet");
	wb_single_a: assert property (!pkt_valid_i |=> !wb_valid_o)
		else $error("descriptor without packet");
	done_set_a: assert property (wb_valid_o |-> wb_desc_o.q1[0])
		else $error("done flag clear on write-back");
	// Error field placement, reserved holes stay empty
	err_map_a: assert property (took_s |-> {wb_desc_o.q1[31:28], wb_desc_o.q1[26:24]} == $past(pkt_info_i.errors))
		else $error("error flags misplaced");
	err_rsvd_a: assert property (took_s |-> wb_desc_o.q1[27] == 1'b0 && wb_desc_o.q1[23:20] == 4'h0)
		else $error("reserved error bits set");
	vlan_place_a: assert property (took_s |-> wb_desc_o.q1[63:48] == $past(pkt_info_i.vlan_tag))
		else $error("vlan tag misplaced");
	ext_len_a: assert property (ext_s |-> wb_desc_o.q1[47:32] == $past(pkt_info_i.length))
		else $error("length misplaced");
	// Non-IPv4 never claims any checksum or ident
	non_ip_flags_a: assert property (took_s ##0 !$past(pkt_info_i.is_ipv4) |-> wb_desc_o.q1[10:9] == 2'b00 && wb_desc_o.q1[5:4] == 2'b00)
		else $error("flags set on non-IPv4 packet");
	rsvd_zero_a: assert property (wb_valid_o |-> wb_desc_o.q3 == 64'h0 && (wb_desc_o.split_format || wb_desc_o.q2 == 64'h0))
		else $error("reserved quadword not zero");
	hdr_len_a: assert property (wb_valid_o && wb_desc_o.split_format && !wb_desc_o.q2[15] |-> wb_desc_o.q2[14:0] == 15'h0)
		else $error("header length without split");
endmodule : rx_wb_monitor
`default_nettype wire

// >>> rx_wb_pkg.sv
`default_nettype none
package rx_wb_pkg;
	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [7:0] REG_SUM_CTRL    = 8'h00;
	localparam logic [7:0] REG_FILTER_CTRL = 8'h04;
	localparam logic [7:0] REG_RX_CTRL     = 8'h08;
	localparam logic [7:0] REG_SPLIT_CTRL  = 8'h0c;
	localparam logic [7:0] REG_STATUS      = 8'h10;
	localparam int SUM_START_POS   = 0;  // sum_start_offset, 8 bits
	localparam int SUM_PAYLOAD_POS = 8;  // ip_payload_sum_enable
	localparam int SUM_L4_POS      = 9;  // l4_offload_enable
	localparam int SUM_HASH_POS    = 13; // hash_vs_sum_select
	localparam int FILT_EXT_POS    = 15; // extended_status_enable
	localparam int RXC_DTYPE_POS   = 10; // descriptor_type, 2 bits
	localparam logic [1:0] DTYPE_SPLIT = 2'h1;
	localparam int BUF_UNIT_SHIFT  = 7;  // sizes in 128-byte units
	localparam logic [31:0] SUM_CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] FILTER_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] RX_CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] SPLIT_CTRL_RST  = 32'h0000_0000;
	// ****************************************
	// Descriptor field positions
	// ****************************************
	localparam int ERR_POS    = 20;
	localparam int LEN_POS    = 32;
	localparam int VLAN_POS   = 48;
	localparam int HSPLIT_BIT = 15;
	localparam int ST_DONE  = 0;
	localparam int ST_EOP   = 1;
	localparam int ST_VLAN  = 3;
	localparam int ST_UDP_SUM_FLAG = 4;
	localparam int ST_TCP_SUM_FLAG = 5;
	localparam int ST_IPCS  = 6;
	localparam int ST_IP_IDENT_VALID = 9;
	localparam int ST_FRAG_UDP_VALID  = 10;
	localparam int ST_KIND  = 16;
	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic rx_data_err;
		logic ipv4_hdr_sum_err;
		logic l4_sum_err;
		logic carrier_ext_err;
		logic order_fault_flag;
		logic symbol_err_flag;
		logic crc_align_err;
	} rx_errors_t;
	typedef struct packed {
		logic [15:0] length;
		logic [15:0] vlan_tag;
		logic        vlan_present;
		logic [3:0]  pkt_kind;
		logic        is_ipv4;
		logic        is_fragment;
		logic        has_udp;
		logic        has_tcp;
		logic        udp_sum_valid;
		logic [15:0] whole_sum;
		logic [15:0] payload_sum;
		logic [15:0] ip_ident;
		logic [31:0] rss_hash;
		logic [31:0] queue_info;
		logic [9:0]  header_len;
		logic        split_capable;
		logic        continuation;
		logic        eop;
		rx_errors_t  errors;
	} rx_pkt_info_t;
	typedef struct packed {
		logic [63:0] q3;
		logic [63:0] q2;
		logic [63:0] q1;
		logic [63:0] q0;
		logic        split_format;
	} rx_wb_desc_t;
endpackage : rx_wb_pkg
`default_nettype wire
